//--- src/swpc_pkg.sv
// shared constants, field layouts and types of the switch port configuration block
package swpc_pkg;
    localparam int NUM_PORTS = 16;
    localparam int NUM_QUADS = 4;
    localparam int PORTS_PER_QUAD = 4;
    localparam int RT_DEPTH = 256;
    localparam int RT_W = 8;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int NUM_ERR_BLK = 4;

    // register map, byte addresses
    localparam logic [23:0] PORT_STAT_BASE = 24'h000158;
    localparam logic [23:0] PORT_CTRL_BASE = 24'h00015C;
    localparam logic [23:0] PORT_STRIDE = 24'h000020;
    localparam logic [23:0] RT_BASE = 24'hE00000;
    localparam logic [23:0] RT_STRIDE = 24'h000004;
    localparam logic [23:0] QUAD_BASE = 24'hFF0000;
    localparam logic [23:0] QUAD_STRIDE = 24'h001000;
    localparam logic [23:0] PORT_OP_BASE = 24'hF40000;
    localparam logic [23:0] DEV_CTRL_ADDR = 24'hF20000;
    localparam logic [23:0] ERR_EN_ADDR = 24'hF20004;
    localparam logic [23:0] BOOT_STAT_ADDR = 24'hF20008;

    // lane group control fields
    localparam int QC_SPEED_LSB = 0;
    localparam int QC_PRE_LSB = 2;
    localparam int QC_MODE_BIT = 5;
    localparam int QC_DRV_LSB = 7;
    localparam int QC_PLL0_BIT = 10;
    localparam int QC_PLL1_BIT = 11;
    localparam int QC_REINIT_BIT = 12;
    localparam logic [31:0] QC_WMASK = 32'h00000FBF;
    localparam logic [31:0] QC_RESET = 32'h00000C20;

    // port control fields
    localparam int PC_IN_EN_BIT = 21;
    localparam int PC_OUT_EN_BIT = 22;
    localparam int PC_WIDTH_LSB = 24;
    localparam logic [31:0] PC_RESET = 32'h00000000;

    // port operation fields
    localparam int PO_RETX_EN_BIT = 0;
    localparam int PO_LIMIT_LSB = 4;
    localparam logic [31:0] PO_RESET = 32'h00000081;

    // device level fields
    localparam int DC_WHOLE_RESET_BIT = 0;
    localparam logic [31:0] DC_RESET = 32'h00000000;
    localparam logic [3:0] ERR_EN_RESET = 4'h0;
    localparam int BOOT_DONE_BIT = 0;
    localparam int BOOT_FAIL_BIT = 1;

    // speed codes and route table values
    localparam logic [1:0] SPD_1G25 = 2'h0;
    localparam logic [1:0] SPD_2G5 = 2'h1;
    localparam logic [1:0] SPD_3G125 = 2'h2;
    localparam logic [7:0] RT_MCAST = 8'h40;
    localparam logic [7:0] RT_RESET = 8'h00;

    typedef struct packed {
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } swpc_req_t;

    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] rdata;
    } swpc_rsp_t;

    typedef enum logic [1:0] {SRC_NONE, SRC_I2C, SRC_JTAG, SRC_MAINT} swpc_src_t;
    typedef enum logic {ST_LOAD, ST_RUN} swpc_boot_t;
endpackage : swpc_pkg

//--- src/swpc_quad_pll.sv
// pll reset decode of one lane group
`timescale 1ns/1ns
module swpc_quad_pll
    import swpc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // control bits: mode bit one means enhanced, pll bits one means released
    input wire logic i_enhanced,
    input wire logic [1:0] i_pll_bits,
    // pll reset, high holds the pll
    output logic [1:0] o_pll_reset,
    output logic o_status_invalid
);
    logic [1:0] next_pll_reset;

    always_comb begin
        if (i_enhanced) begin
            next_pll_reset = ~i_pll_bits; // see [R11]
        end else begin
            // mismatched bits are unsafe, so keep both held
            next_pll_reset = {2{~(&i_pll_bits)}}; // see [R19]
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pll_reset <= 2'h0;
            o_status_invalid <= 1'b0;
        end else begin
            o_pll_reset <= next_pll_reset;
            o_status_invalid <= |next_pll_reset; // see [R12]
        end
    end
endmodule : swpc_quad_pll

//--- src/swpc_route_table.sv
// destination route table with a register port and a lookup port
`timescale 1ns/1ns
module swpc_route_table
    import swpc_pkg::*;
#(
    parameter int DEPTH = RT_DEPTH,
    parameter int W = RT_W
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // register port
    input wire logic i_we,
    input wire logic [7:0] i_idx,
    input wire logic [W-1:0] i_wdata,
    output logic [W-1:0] o_rdata,
    // lookup port
    input wire logic i_lk_valid,
    input wire logic [7:0] i_lk_dest,
    output logic o_lk_valid,
    output logic [W-1:0] o_lk_port,
    output logic o_lk_mcast
);
    logic [W-1:0] entry [DEPTH];

    assign o_rdata = entry[i_idx];

    // one word per destination, holding the egress port
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                entry[i] <= RT_RESET;
            end
        end else if (i_we) begin
            entry[i_idx] <= i_wdata; // see [R16]
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_lk_valid <= 1'b0;
            o_lk_port <= '0;
            o_lk_mcast <= 1'b0;
        end else begin
            o_lk_valid <= i_lk_valid;
            o_lk_port <= entry[i_lk_dest];
            o_lk_mcast <= (entry[i_lk_dest] == W'(RT_MCAST)); // see [R17]
        end
    end
endmodule : swpc_route_table

//--- src/swpc_config_regs.sv
// configuration register set of the switch: ports, lane groups, route table
`timescale 1ns/1ns
// What this block does
// [R1] ports reset to defaults, speed from straps
// [R2] strap 00/01/10 give 1.25/2.5/3.125 Gb/s
// [R3] eeprom boot result shown in boot status
// [R4] i2c, jtag and maintenance all reach registers
// [R5] block error report enables reset disabled
// [R6] only enabled blocks forward their errors
// [R7] control bit picks device or port reset
// [R8] lane group speed, pre-emphasis, drive fields
// [R9] bit 5 picks standard or enhanced mode
// [R10] standard mode: software writes both pll bits alike
// [R11] enhanced mode: pll bits act independently
// [R12] port status invalid while pll held
// [R13] software forces single lane via width field
// [R14] port operation: retransmit enable and limit
// [R15] software writes reinit after lane group changes
// [R16] route table word per destination id
// [R17] route value 0x40 means multicast
// [R18] port inputs and outputs reset disabled
// [R19] standard mode mismatched pll bits hold reset
module swpc_config_regs
    import swpc_pkg::*;
#(
    parameter int NP = NUM_PORTS,
    parameter int NQ = NUM_QUADS
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // speed straps
    input wire logic i_rate_strap_low,
    input wire logic i_rate_strap_high,
    // register access paths
    input wire swpc_req_t i_i2c_req,
    input wire swpc_req_t i_jtag_req,
    input wire swpc_req_t i_maint_req,
    output swpc_rsp_t o_i2c_rsp,
    output swpc_rsp_t o_jtag_rsp,
    output swpc_rsp_t o_maint_rsp,
    // eeprom boot and error reporting
    input wire logic i_boot_done,
    input wire logic i_boot_fail,
    input wire logic [NUM_ERR_BLK-1:0] i_blk_err,
    output logic [NUM_ERR_BLK-1:0] o_err_fwd,
    // link reset sequences and port status
    input wire logic [NP-1:0] i_reset_seq,
    input wire logic [NP-1:0] i_link_ok,
    output logic o_device_reset,
    output logic [NP-1:0] o_port_reset,
    // route lookup
    input wire logic i_lookup_valid,
    input wire logic [7:0] i_lookup_dest,
    output logic o_lookup_valid,
    output logic [7:0] o_lookup_port,
    output logic o_lookup_mcast,
    // port settings
    output logic [NP-1:0] o_port_in_en,
    output logic [NP-1:0] o_port_out_en,
    output logic [NP-1:0][2:0] o_lane_width_force,
    output logic [NP-1:0] o_retx_enable,
    output logic [NP-1:0][7:0] o_retx_limit,
    // lane group settings
    output logic [NQ-1:0][1:0] o_quad_speed,
    output logic [NQ-1:0][2:0] o_quad_preemph,
    output logic [NQ-1:0][2:0] o_quad_drive,
    output logic [NQ-1:0] o_quad_enhanced,
    output logic [NQ-1:0][1:0] o_pll_reset,
    output logic [NQ-1:0] o_quad_reinit
);
    function automatic int slot_of(logic [23:0] a, logic [23:0] base, logic [23:0] stride,
                                   int count);
        logic [23:0] off;
        off = a - base;
        if ((off % stride) == 24'h0 && (off / stride) < 24'(count)) begin
            return int'(off / stride);
        end
        return -1;
    endfunction : slot_of

    function automatic logic [1:0] strap_speed(logic [1:0] s);
        case (s)
            2'h1: return SPD_2G5;
            2'h2: return SPD_3G125;
            default: return SPD_1G25; // reserved pattern falls back to slowest
        endcase
    endfunction : strap_speed

    swpc_boot_t boot_st, next_boot_st;
    logic [NP-1:0][31:0] port_ctrl, next_port_ctrl;
    logic [NP-1:0][31:0] port_op, next_port_op;
    logic [NQ-1:0][31:0] quad_ctrl, next_quad_ctrl;
    logic [31:0] dev_ctrl, next_dev_ctrl;
    logic [3:0] err_en, next_err_en;
    logic [1:0] boot_stat, next_boot_stat;
    logic [NQ-1:0] next_reinit;
    logic [NUM_ERR_BLK-1:0] next_err_fwd;
    logic next_device_reset;
    logic [NP-1:0] next_port_reset;
    swpc_rsp_t next_i2c_rsp, next_jtag_rsp, next_maint_rsp;
    swpc_src_t gnt;
    swpc_req_t g;
    logic [31:0] rdata;
    logic rt_we;
    logic [7:0] rt_rdata;
    logic [NQ-1:0] quad_invalid;
    int ps, pc, po, qs, rs;

    // fixed priority: i2c, then jtag, then in-band maintenance
    always_comb begin
        gnt = SRC_NONE;
        g = '0;
        if (boot_st == ST_RUN) begin
            if (i_i2c_req.req && !o_i2c_rsp.ack) begin
                gnt = SRC_I2C; // see [R4]
                g = i_i2c_req;
            end else if (i_jtag_req.req && !o_jtag_rsp.ack) begin
                gnt = SRC_JTAG; // see [R4]
                g = i_jtag_req;
            end else if (i_maint_req.req && !o_maint_rsp.ack) begin
                gnt = SRC_MAINT; // see [R4]
                g = i_maint_req;
            end
        end
        ps = slot_of(g.addr, PORT_STAT_BASE, PORT_STRIDE, NP);
        pc = slot_of(g.addr, PORT_CTRL_BASE, PORT_STRIDE, NP);
        po = slot_of(g.addr, PORT_OP_BASE, PORT_STRIDE, NP);
        qs = slot_of(g.addr, QUAD_BASE, QUAD_STRIDE, NQ);
        rs = slot_of(g.addr, RT_BASE, RT_STRIDE, RT_DEPTH);
    end

    assign rt_we = (gnt != SRC_NONE) && g.we && (rs >= 0);

    // reads of unmapped space return zero
    always_comb begin
        rdata = 32'h0;
        if (ps >= 0) begin
            rdata[0] = quad_invalid[ps / PORTS_PER_QUAD];
            rdata[1] = i_link_ok[ps] && !quad_invalid[ps / PORTS_PER_QUAD]; // see [R12]
        end else if (pc >= 0) begin
            rdata = port_ctrl[pc];
        end else if (po >= 0) begin
            rdata = port_op[po];
        end else if (qs >= 0) begin
            rdata = quad_ctrl[qs];
        end else if (rs >= 0) begin
            rdata = {24'h0, rt_rdata};
        end else if (g.addr == DEV_CTRL_ADDR) begin
            rdata = dev_ctrl;
        end else if (g.addr == ERR_EN_ADDR) begin
            rdata = {28'h0, err_en};
        end else if (g.addr == BOOT_STAT_ADDR) begin
            rdata = {30'h0, boot_stat};
        end
    end

    always_comb begin
        next_boot_st = boot_st;
        next_port_ctrl = port_ctrl;
        next_port_op = port_op;
        next_quad_ctrl = quad_ctrl;
        next_dev_ctrl = dev_ctrl;
        next_err_en = err_en;
        next_boot_stat = boot_stat;
        next_reinit = '0;
        case (boot_st)
            ST_LOAD: begin
                // straps are caught on the first edge after release
                for (int q = 0; q < NQ; q++) begin
                    next_quad_ctrl[q][QC_SPEED_LSB +: 2] =
                        strap_speed({i_rate_strap_high, i_rate_strap_low}); // see [R1] [R2]
                end
                next_boot_st = ST_RUN;
            end
            default: begin
                if (gnt != SRC_NONE && g.we) begin
                    if (pc >= 0) begin
                        // enables and lane width force live here
                        next_port_ctrl[pc] = g.wdata; // see [R18] [R13]
                    end else if (po >= 0) begin
                        next_port_op[po] = g.wdata; // see [R14]
                    end else if (qs >= 0) begin
                        // speed, pre-emphasis, mode, drive, pll bits
                        next_quad_ctrl[qs] = g.wdata & QC_WMASK; // see [R8] [R9]
                        next_reinit[qs] = g.wdata[QC_REINIT_BIT]; // see [R15]
                    end else if (g.addr == DEV_CTRL_ADDR) begin
                        next_dev_ctrl = g.wdata;
                    end else if (g.addr == ERR_EN_ADDR) begin
                        next_err_en = g.wdata[3:0];
                    end else if (g.addr == BOOT_STAT_ADDR) begin
                        next_boot_stat = boot_stat & ~g.wdata[1:0];
                    end
                end
            end
        endcase
        // hardware set wins over a clear in the same cycle
        next_boot_stat[BOOT_DONE_BIT] = next_boot_stat[BOOT_DONE_BIT] | i_boot_done; // see [R3]
        next_boot_stat[BOOT_FAIL_BIT] = next_boot_stat[BOOT_FAIL_BIT] | i_boot_fail; // see [R3]
    end

    always_comb begin
        next_i2c_rsp = '{ack: (gnt == SRC_I2C), rdata: (gnt == SRC_I2C) ? rdata : 32'h0};
        next_jtag_rsp = '{ack: (gnt == SRC_JTAG), rdata: (gnt == SRC_JTAG) ? rdata : 32'h0};
        next_maint_rsp = '{ack: (gnt == SRC_MAINT), rdata: (gnt == SRC_MAINT) ? rdata : 32'h0};
        next_err_fwd = i_blk_err & err_en; // see [R6]
        next_device_reset = dev_ctrl[DC_WHOLE_RESET_BIT] && (|i_reset_seq); // see [R7]
        next_port_reset = dev_ctrl[DC_WHOLE_RESET_BIT] ? '0 : i_reset_seq; // see [R7]
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boot_st <= ST_LOAD;
            port_ctrl <= {NP{PC_RESET}}; // see [R18]
            port_op <= {NP{PO_RESET}};
            quad_ctrl <= {NQ{QC_RESET}};
            dev_ctrl <= DC_RESET;
            err_en <= ERR_EN_RESET; // see [R5]
            boot_stat <= 2'h0;
            o_quad_reinit <= '0;
            o_err_fwd <= '0;
            o_device_reset <= 1'b0;
            o_port_reset <= '0;
            o_i2c_rsp <= '0;
            o_jtag_rsp <= '0;
            o_maint_rsp <= '0;
        end else begin
            boot_st <= next_boot_st;
            port_ctrl <= next_port_ctrl;
            port_op <= next_port_op;
            quad_ctrl <= next_quad_ctrl;
            dev_ctrl <= next_dev_ctrl;
            err_en <= next_err_en;
            boot_stat <= next_boot_stat;
            o_quad_reinit <= next_reinit;
            o_err_fwd <= next_err_fwd;
            o_device_reset <= next_device_reset;
            o_port_reset <= next_port_reset;
            o_i2c_rsp <= next_i2c_rsp;
            o_jtag_rsp <= next_jtag_rsp;
            o_maint_rsp <= next_maint_rsp;
        end
    end

    // fields are bits of the registers above, so outputs stay flop driven
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            o_port_in_en[p] = port_ctrl[p][PC_IN_EN_BIT];
            o_port_out_en[p] = port_ctrl[p][PC_OUT_EN_BIT];
            o_lane_width_force[p] = port_ctrl[p][PC_WIDTH_LSB +: 3];
            o_retx_enable[p] = port_op[p][PO_RETX_EN_BIT];
            o_retx_limit[p] = port_op[p][PO_LIMIT_LSB +: 8];
        end
        for (int q = 0; q < NQ; q++) begin
            o_quad_speed[q] = quad_ctrl[q][QC_SPEED_LSB +: 2];
            o_quad_preemph[q] = quad_ctrl[q][QC_PRE_LSB +: 3];
            o_quad_drive[q] = quad_ctrl[q][QC_DRV_LSB +: 3];
            o_quad_enhanced[q] = quad_ctrl[q][QC_MODE_BIT];
        end
    end

    for (genvar q = 0; q < NQ; q++) begin : g_quad
        swpc_quad_pll u_pll (
            .i_clock(i_clock),
            .i_rst_b(i_rst_b),
            .i_enhanced(quad_ctrl[q][QC_MODE_BIT]),
            .i_pll_bits({quad_ctrl[q][QC_PLL1_BIT], quad_ctrl[q][QC_PLL0_BIT]}),
            .o_pll_reset(o_pll_reset[q]),
            .o_status_invalid(quad_invalid[q])
        );
    end

    swpc_route_table u_rt (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_we(rt_we),
        .i_idx(rs[7:0]),
        .i_wdata(g.wdata[7:0]),
        .o_rdata(rt_rdata),
        .i_lk_valid(i_lookup_valid),
        .i_lk_dest(i_lookup_dest),
        .o_lk_valid(o_lookup_valid),
        .o_lk_port(o_lookup_port),
        .o_lk_mcast(o_lookup_mcast)
    );

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    AST_STRAP_SPEED: assert property ( // see [R1] [R2]
        (boot_st == ST_LOAD) |=> (o_quad_speed[0] ==
            strap_speed($past({i_rate_strap_high, i_rate_strap_low}))))
        else $error("lane group speed does not follow straps");
    AST_ERR_EN_OFF: assert property ( // see [R5]
        (boot_st == ST_LOAD) |-> (err_en == 4'h0))
        else $error("error enables not cleared by reset");
    AST_PORTS_OFF: assert property ( // see [R18]
        (boot_st == ST_LOAD) |-> (o_port_in_en == '0 && o_port_out_en == '0))
        else $error("ports enabled out of reset");
    AST_ERR_FWD: assert property ( // see [R6]
        ##1 (o_err_fwd == $past(i_blk_err & err_en)))
        else $error("error forwarding ignores enables");
    AST_RESET_SCOPE: assert property ( // see [R7]
        (|i_reset_seq) |=> (o_device_reset == $past(dev_ctrl[DC_WHOLE_RESET_BIT]))
            && ((o_port_reset == '0) == $past(dev_ctrl[DC_WHOLE_RESET_BIT])))
        else $error("reset sequence scope wrong");
    AST_BOOT_STICKY: assert property ( // see [R3]
        i_boot_fail |=> boot_stat[BOOT_FAIL_BIT] ##1 (boot_stat[BOOT_FAIL_BIT]
            || $past(gnt != SRC_NONE && g.we && g.addr == BOOT_STAT_ADDR)))
        else $error("boot failure not held");
    AST_I2C_ACK: assert property ( // see [R4]
        (gnt == SRC_I2C) |=> o_i2c_rsp.ack ##1 !o_i2c_rsp.ack)
        else $error("i2c access not answered once");
    AST_MCAST: assert property ( // see [R17]
        o_lookup_valid |-> (o_lookup_mcast == (o_lookup_port == RT_MCAST)))
        else $error("multicast flag wrong");
    AST_PLL_STD: assert property ( // see [R19]
        (!quad_ctrl[0][QC_MODE_BIT] && !(&quad_ctrl[0][QC_PLL1_BIT:QC_PLL0_BIT]))
            |=> (o_pll_reset[0] == 2'h3))
        else $error("standard mode pll not held");
    AST_REINIT: assert property ( // see [R15]
        (gnt != SRC_NONE && g.we && qs == 0 && g.wdata[QC_REINIT_BIT])
            |=> o_quad_reinit[0] ##1 !o_quad_reinit[0])
        else $error("reinit pulse missing");

    COV_MCAST: cover property (o_lookup_valid && o_lookup_mcast);
    COV_DEV_RESET: cover property (o_device_reset);
    COV_PLL_SPLIT: cover property (o_pll_reset[0] == 2'h1);
    COV_BOOT_FAIL: cover property (boot_stat[BOOT_FAIL_BIT]);
endmodule : swpc_config_regs

//--- sim/swpc_host.sv
// host model: register accesses on the i2c, jtag and maintenance paths
`timescale 1ns/1ns
module swpc_host
    import swpc_pkg::*;
(
    // clock
    input wire logic i_clock,
    // requests and answers, 0 i2c 1 jtag 2 maintenance
    output swpc_req_t o_req [3],
    input wire swpc_rsp_t i_rsp [3],
    // a request that was never answered
    output logic o_hang
);
    initial begin
        o_req = '{default: '0};
        o_hang = 1'b0;
    end

    // any path reaches the same registers
    task automatic xfer(input logic [1:0] p, input logic we, input logic [23:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(negedge i_clock);
        o_req[p] = '{1'b1, we, a, d};
        do begin
            @(posedge i_clock);
            n++;
        end while (i_rsp[p].ack !== 1'b1 && n < 40);
        q = i_rsp[p].rdata;
        o_hang = (i_rsp[p].ack !== 1'b1);
        @(negedge i_clock);
        // released lines change, so a stale value cannot pass
        o_req[p] = '{1'b0, ~we, ~a, ~d};
    endtask : xfer
endmodule : swpc_host

//--- sim/tb_swpc_config_regs.sv
// self-checking bench of the switch port configuration registers
`timescale 1ns/1ns
module tb_swpc_config_regs import swpc_pkg::*; ;
    logic i_clock;
    logic i_rst_b;
    logic sl, sh, bdone, bfail, lv, lvo, lmc, drst, hang;
    logic [3:0] berr, efwd, enh, reinit;
    logic [7:0] ld, lport;
    logic [15:0] rseq, lok, prst, pin, pout, retx;
    logic [15:0][2:0] lwf;
    logic [15:0][7:0] rlim;
    logic [3:0][1:0] spd, pll;
    logic [3:0][2:0] pre, drv;
    logic [31:0] q;
    swpc_req_t rq [3];
    swpc_rsp_t rs [3];
    int n_fail = 0;
    int samples_checked = 0;
    int n_reinit = 0;

    swpc_config_regs i_swpc_config_regs (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_rate_strap_low(sl), .i_rate_strap_high(sh),
        .i_i2c_req(rq[0]), .i_jtag_req(rq[1]), .i_maint_req(rq[2]),
        .o_i2c_rsp(rs[0]), .o_jtag_rsp(rs[1]), .o_maint_rsp(rs[2]),
        .i_boot_done(bdone), .i_boot_fail(bfail), .i_blk_err(berr), .o_err_fwd(efwd),
        .i_reset_seq(rseq), .i_link_ok(lok), .o_device_reset(drst), .o_port_reset(prst),
        .i_lookup_valid(lv), .i_lookup_dest(ld), .o_lookup_valid(lvo),
        .o_lookup_port(lport), .o_lookup_mcast(lmc), .o_port_in_en(pin),
        .o_port_out_en(pout), .o_lane_width_force(lwf), .o_retx_enable(retx),
        .o_retx_limit(rlim), .o_quad_speed(spd), .o_quad_preemph(pre), .o_quad_drive(drv),
        .o_quad_enhanced(enh), .o_pll_reset(pll), .o_quad_reinit(reinit));
    swpc_host i_swpc_host (.i_clock(i_clock), .o_req(rq), .i_rsp(rs), .o_hang(hang));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // reinit stands one cycle inside an access, so count it where it stands
    always @(negedge i_clock) begin
        if (reinit[0] === 1'b1) begin
            n_reinit++;
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(negedge i_clock);
    endtask : cyc

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // a hung access counts as a mismatch and ends the run
    task automatic acc(input logic [1:0] p, input logic we, input logic [23:0] a,
        input logic [31:0] d);
        i_swpc_host.xfer(p, we, a, d, q);
        if (hang !== 1'b0) begin
            n_fail++;
            finish_test();
        end
    endtask : acc

    task automatic t_straps;
        logic [1:0] e [4] = '{SPD_1G25, SPD_2G5, SPD_3G125, SPD_1G25};
        for (int s = 0; s < 4; s++) begin
            i_rst_b = 1'b0;
            {sh, sl} = s[1:0];
            cyc(3);
            i_rst_b = 1'b1;
            cyc(3);
            chk("speed", 32'(spd[3]), 32'(e[s]));
            acc(2'h0, 1'b0, QUAD_BASE, '0);
            chk("lane group", q, QC_RESET | 32'(e[s]));
        end
        chk("port enables", {pin, pout}, '0);
        acc(2'h1, 1'b0, ERR_EN_ADDR, '0);
        chk("error enables", q, 32'(ERR_EN_RESET));
    endtask : t_straps

    task automatic t_ports;
        acc(2'h0, 1'b1, PORT_CTRL_BASE, 32'h01600000);
        acc(2'h1, 1'b1, 24'h00033C, 32'h00200000);
        acc(2'h2, 1'b1, 24'h00035C, 32'h00600000);
        acc(2'h2, 1'b1, PORT_OP_BASE + PORT_STRIDE, 32'h000003C1);
        cyc(1);
        chk("in enables", 32'(pin), 32'h00008001);
        chk("out enables", 32'(pout), 32'h00000001);
        chk("width force", 32'(lwf[0]), 32'h00000001);
        chk("retransmit", 32'({retx[1], rlim[1]}), 32'h0000013C);
        acc(2'h2, 1'b0, PORT_CTRL_BASE, '0);
        chk("port control", q, 32'h01600000);
        acc(2'h0, 1'b0, 24'h00035C, '0);
        chk("absent port", q, '0);
    endtask : t_ports

    task automatic t_quad;
        logic [31:0] d [5] = '{32'h28E, 32'h68E, 32'hE8E, 32'h6AE, 32'hAAE};
        logic [1:0] e [5] = '{2'h3, 2'h3, 2'h0, 2'h2, 2'h1};
        lok = '1;
        for (int i = 0; i < 5; i++) begin
            acc(2'h0, 1'b1, QUAD_BASE, d[i]);
            cyc(1);
            chk("pll reset", 32'(pll[0]), 32'(e[i]));
            chk("mode", 32'(enh[0]), 32'(d[i][5]));
            acc(2'h1, 1'b0, PORT_STAT_BASE, '0);
            chk("port status", 32'(q[1:0]), (e[i] != 2'h0) ? 32'h1 : 32'h2);
        end
        chk("lane fields", 32'({spd[0], pre[0], drv[0]}), 32'h0000009D);
        chk("no early reinit", 32'(n_reinit), 32'h0);
        acc(2'h2, 1'b1, QUAD_BASE, 32'h00001E8E);
        cyc(1);
        chk("reinit pulses", 32'(n_reinit), 32'h1);
        acc(2'h0, 1'b0, QUAD_BASE, '0);
        chk("reinit reads", q, 32'h00000E8E);
    endtask : t_quad

    task automatic t_route;
        logic [7:0] dst [3] = '{8'h00, 8'h01, 8'hFF};
        logic [9:0] e [3] = '{10'h208, 10'h300, 10'h205};
        acc(2'h0, 1'b1, RT_BASE, 32'h8);
        acc(2'h1, 1'b1, RT_BASE + RT_STRIDE, 32'h40);
        acc(2'h2, 1'b1, 24'hE003FC, 32'h5);
        acc(2'h0, 1'b1, 24'hE00400, 32'h7);
        acc(2'h1, 1'b0, 24'hE00400, '0);
        chk("route end", q, '0);
        for (int i = 0; i < 3; i++) begin
            lv = 1'b1;
            ld = dst[i];
            cyc(1);
            chk("lookup", 32'({lvo, lmc, lmc ? 8'h00 : lport}), 32'(e[i]));
        end
        lv = 1'b0;
    endtask : t_route

    task automatic t_events;
        berr = 4'hF;
        cyc(2);
        chk("forward off", 32'(efwd), '0);
        acc(2'h0, 1'b1, ERR_EN_ADDR, 32'h5);
        cyc(1);
        chk("forward on", 32'(efwd), 32'h5);
        berr = 4'h0;
        rseq = 16'h0008;
        cyc(1);
        chk("port reset", 32'({drst, prst}), 32'h00008);
        rseq = '0;
        acc(2'h1, 1'b1, DEV_CTRL_ADDR, 32'h1);
        rseq = 16'h0008;
        cyc(1);
        chk("device reset", 32'({drst, prst}), 32'h10000);
        {rseq, bdone, bfail} = {16'h0, 2'h3};
        cyc(1);
        {bdone, bfail} = 2'h0;
        acc(2'h2, 1'b0, BOOT_STAT_ADDR, '0);
        chk("boot status", q, 32'h3);
        acc(2'h2, 1'b1, BOOT_STAT_ADDR, 32'h3);
        acc(2'h0, 1'b0, BOOT_STAT_ADDR, '0);
        chk("boot cleared", q, '0);
    endtask : t_events

    initial begin
        i_rst_b = 1'b0;
        {sl, sh, bdone, bfail, lv, berr, rseq, lok, ld} = '0;
        t_straps();
        t_ports();
        t_quad();
        t_route();
        t_events();
        finish_test();
    end
endmodule : tb_swpc_config_regs
